// File: hw/ldr_defines.svh
// register bit positions and timing constants for the load driver block
`ifndef LDR_DEFINES_SVH
`define LDR_DEFINES_SVH
`define LDR_SEL_BIT 0
`define LDR_CTL_PWM_LO 1
`define LDR_CTL_REC_LO 6
`define LDR_CTL_DUTY_BIT 13
`define LDR_CTL_DOL_BIT 14
`define LDR_CTL_RESET_BIT 0
`define LDR_ST_ALWAYS1 15
`define LDR_ST_OV 14
`define LDR_ST_UV 13
`define LDR_ST_TSD 12
`define LDR_ST_TW 11
`define LDR_ST_NRDY 10
`define LDR_ST_OL_LO 1
`define LDR_CLK_NS 25
`define LDR_OL_FILT_NS 1000000
`define LDR_OL_FILT_CYC ((`LDR_OL_FILT_NS + `LDR_CLK_NS - 1) / `LDR_CLK_NS)
`define LDR_TICK_NS 100000
`define LDR_TICK_CYC (`LDR_TICK_NS / `LDR_CLK_NS)
`define LDR_START_TICKS 8
`define LDR_REC_LONG_TICKS 4
`define LDR_REC_SHORT_TICKS 1
`endif

// File: hw/ldr_pkg.sv
// types shared by the load driver logic
package ldr_pkg;
  typedef struct packed {
    logic [4:0] over_current;
    logic [7:0] open_load_raw;
    logic over_voltage;
    logic under_voltage;
    logic over_temp;
    logic temp_warning;
  } ldr_sense_type;
  typedef enum logic [2:0] {
    LDR_STANDBY = 3'b001,
    LDR_STARTING = 3'b010,
    LDR_ACTIVE = 3'b100
  } ldr_mode_type;
endpackage

// File: hw/ldr_recovery.sv
// over-current latch and automatic retry for one output
`timescale 1ns/10ps
`include "ldr_defines.svh"
module ldr_recovery
  import ldr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_over_current,
  input wire logic i_recovery_en,
  input wire logic i_duty_long,
  input wire logic i_clear,
  output logic o_flag,
  output logic o_block
);
  typedef struct packed {
    logic flag;
    logic pend;
    logic [3:0] cnt;
  } ldr_rec_state_type;
  ldr_rec_state_type st;
  ldr_rec_state_type next_st;
  logic [3:0] delay;
  assign delay = i_duty_long ? 4'(`LDR_REC_LONG_TICKS)
                             : 4'(`LDR_REC_SHORT_TICKS);
  always_comb begin
    next_st = st;
    if (i_clear) begin
      next_st.flag = 1'b0;
      next_st.pend = 1'b0;
    end
    if (st.pend && i_tick) begin
      if (st.cnt <= 4'h1) begin
        next_st.pend = 1'b0;
        next_st.flag = 1'b0;
      end else begin
        next_st.cnt = st.cnt - 4'h1;
      end
    end
    // retry armed by the enable, or without it when a tick falls in the event's cycle
    if (i_over_current) begin
      next_st.flag = 1'b1;
      if (i_recovery_en || i_tick) begin
        next_st.pend = 1'b1;
        next_st.cnt = delay;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_flag = st.flag;
  assign o_block = st.flag;
endmodule

// File: hw/ldr_regs.sv
// recovery, pwm control and second status frame of the load driver
`timescale 1ns/10ps
`include "ldr_defines.svh"
// Functional notes
// - over-current sets that output's flag and switches the output off
// - recovery enable re-enables output after delay; bit 13 sets duty
// - control bits 10..6 are recovery enables for outputs five..one
// - one retry may occur without enable, depending on clock phase
// - bits 5..1 gate enabled outputs by the pwm pin
// - standby to active starts timer; not-ready bit 10 until expiry
// - not-ready is timed by the internal tick clock
// - status bits 8..1 open-load flags after 1 ms low current
// - bit 0 is NOR of bits 1..14 and the over-current flags, open load masked by bit 14
// - over/under voltage set bits 14/13 and disable all outputs
// - thermal shutdown sets bit 12, cleared by reset bit write
// - bit 11 is temperature warning, information only
module ldr_regs
  import ldr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_frame_valid,
  input wire logic [15:0] i_frame,
  input wire logic i_active_req,
  input wire logic [4:0] i_out_enable,
  input wire logic i_reset_bit,
  input wire logic [4:0] i_first_oc,
  input wire logic i_pwm_pin,
  input wire ldr_sense_type i_sense,
  output logic [15:0] o_status,
  output logic [4:0] o_drive,
  output logic [4:0] o_oc_flags,
  output logic o_not_ready
);
  typedef struct packed {
    logic [15:0] ctl;
    ldr_mode_type mode;
    logic [15:0] tick_cnt;
    logic [3:0] start_cnt;
    logic [7:0] ol_flag;
    logic thermal_shutdown_flag;
    logic [15:0] status;
    logic [4:0] drive;
    logic [1:0] pwm_sync;
    logic [1:0] act_sync;
  } ldr_reg_state_type;
  ldr_reg_state_type st;
  ldr_reg_state_type next_st;
  logic tick;
  logic [4:0] oc_flag;
  logic [4:0] oc_block;
  logic [7:0] ol_hit;
  logic [7:0] drv_on;
  logic [15:0] sts;
  logic clear_oc;

  function automatic logic [7:0] ol_map(input logic [4:0] d);
    // half bridges report as one pair here; high-sides as one bit
    ol_map = {d[4], d[3], d[2], d[2], d[1], d[1], d[0], d[0]};
  endfunction

  assign tick = (st.tick_cnt == 16'(`LDR_TICK_CYC - 1));
  assign clear_oc = i_reset_bit;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_rec
      ldr_recovery u_rec (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_tick(tick),
        .i_over_current(i_sense.over_current[g] | i_first_oc[g]),
        .i_recovery_en(st.ctl[`LDR_CTL_REC_LO + g]),
        .i_duty_long(st.ctl[`LDR_CTL_DUTY_BIT]),
        .i_clear(clear_oc),
        .o_flag(oc_flag[g]),
        .o_block(oc_block[g])
      );
    end
  endgenerate

  ldr_olfilt u_ol (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_active(drv_on),
    .i_low_current(i_sense.open_load_raw),
    .o_hit(ol_hit)
  );

  assign drv_on = ol_map(st.drive);

  always_comb begin
    logic [4:0] gated;
    logic global_off;
    logic [13:0] nor_src;
    gated = '0;
    global_off = 1'b0;
    nor_src = '0;
    next_st = st;
    next_st.pwm_sync = {st.pwm_sync[0], i_pwm_pin};
    next_st.act_sync = {st.act_sync[0], i_active_req};
    next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
    if (i_frame_valid && i_frame[`LDR_SEL_BIT]) begin
      next_st.ctl = i_frame;
    end
    case (st.mode)
      LDR_STANDBY: begin
        if (st.act_sync[1]) begin
          next_st.mode = LDR_STARTING;
          next_st.start_cnt = 4'(`LDR_START_TICKS);
        end
      end
      LDR_STARTING: begin
        if (!st.act_sync[1]) begin
          next_st.mode = LDR_STANDBY;
        end else if (tick) begin
          if (st.start_cnt == 4'h1) begin
            next_st.mode = LDR_ACTIVE;
          end
          next_st.start_cnt = st.start_cnt - 4'h1;
        end
      end
      LDR_ACTIVE: begin
        if (!st.act_sync[1]) begin
          next_st.mode = LDR_STANDBY;
        end
      end
      default: begin
        next_st.mode = LDR_STANDBY;
      end
    endcase
    // set wins over the reset-bit clear
    if (i_reset_bit) begin
      next_st.thermal_shutdown_flag = 1'b0;
      next_st.ol_flag = '0;
    end
    if (i_sense.over_temp) begin
      next_st.thermal_shutdown_flag = 1'b1;
    end
    next_st.ol_flag = next_st.ol_flag | ol_hit;
    global_off = i_sense.over_voltage | i_sense.under_voltage
               | st.thermal_shutdown_flag | i_sense.over_temp
               | (st.mode != LDR_ACTIVE);
    for (int i = 0; i < 5; i++) begin
      gated[i] = i_out_enable[i] & ~oc_block[i];
      if (st.ctl[`LDR_CTL_PWM_LO + i]) begin
        gated[i] = gated[i] & st.pwm_sync[1];
      end
    end
    next_st.drive = global_off ? 5'h00 : gated;
    nor_src = {i_sense.over_voltage, i_sense.under_voltage,
               st.thermal_shutdown_flag, i_sense.temp_warning,
               (st.mode != LDR_ACTIVE), 1'b0,
               st.ol_flag & {8{~st.ctl[`LDR_CTL_DOL_BIT]}}};
    // status keeps open-load flags visible; only the summary masks them
    sts = {1'b1, nor_src[13:8], st.ol_flag, 1'b0};
    // all five outputs' over-current flags join the summary
    sts[0] = ~(|nor_src) & ~(|oc_flag);
    next_st.status = sts;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
      st.mode <= LDR_STANDBY;
      st.status <= 16'h8000;
    end else begin
      st <= next_st;
    end
  end

  assign o_status = st.status;
  assign o_drive = st.drive;
  assign o_oc_flags = oc_flag;
  assign o_not_ready = st.status[`LDR_ST_NRDY];

  property p_always1;
    @(posedge i_clk) disable iff (i_rst) o_status[15];
  endproperty
  a_always1: assert property (p_always1) else $error("bit15 low");

  property p_oc_off;
    @(posedge i_clk) disable iff (i_rst)
      i_sense.over_current[0] |=> ##1 !o_drive[0];
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("oc drive on");

  property p_uv_off;
    @(posedge i_clk) disable iff (i_rst)
      i_sense.under_voltage |=> o_drive == 5'h00;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("uv drive on");

  property p_uv_bit;
    @(posedge i_clk) disable iff (i_rst)
      i_sense.under_voltage |=> o_status[13] && !o_status[0];
  endproperty
  a_uv_bit: assert property (p_uv_bit) else $error("uv bit");

  property p_tsd_hold;
    @(posedge i_clk) disable iff (i_rst)
      st.thermal_shutdown_flag && !i_reset_bit |=> st.thermal_shutdown_flag;
  endproperty
  a_tsd_hold: assert property (p_tsd_hold) else $error("tsd lost");

  property p_nrdy_off;
    @(posedge i_clk) disable iff (i_rst)
      st.mode != LDR_ACTIVE |=> o_drive == 5'h00;
  endproperty
  a_nrdy_off: assert property (p_nrdy_off) else $error("drv early");

  property p_nrdy_tick;
    @(posedge i_clk) disable iff (i_rst)
      $fell(st.mode == LDR_STARTING) && st.act_sync[1] |-> $past(tick);
  endproperty
  a_nrdy_tick: assert property (p_nrdy_tick) else $error("no tick");

  property p_pwm_gate;
    @(posedge i_clk) disable iff (i_rst)
      st.ctl[1] && !st.pwm_sync[1] |=> !o_drive[0];
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("pwm gate");

  property p_nor;
    @(posedge i_clk) disable iff (i_rst)
      o_status[14] |-> !o_status[0];
  endproperty
  a_nor: assert property (p_nor) else $error("no error bit");

  property p_warn;
    @(posedge i_clk) disable iff (i_rst)
      i_sense.temp_warning |=> o_status[11];
  endproperty
  a_warn: assert property (p_warn) else $error("warn bit");

  property p_sel_skip;
    @(posedge i_clk) disable iff (i_rst)
      i_frame_valid && !i_frame[`LDR_SEL_BIT] |=> $stable(st.ctl);
  endproperty
  a_sel_skip: assert property (p_sel_skip) else $error("sel skip");

  property p_sel_take;
    @(posedge i_clk) disable iff (i_rst)
      i_frame_valid && i_frame[`LDR_SEL_BIT] |=> st.ctl == $past(i_frame);
  endproperty
  a_sel_take: assert property (p_sel_take) else $error("sel take");

  property p_tsd_off;
    @(posedge i_clk) disable iff (i_rst)
      st.thermal_shutdown_flag |=> o_drive == 5'h00;
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("tsd on");

  property p_ov_off;
    @(posedge i_clk) disable iff (i_rst)
      i_sense.over_voltage |=> o_drive == 5'h00;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("ov on");

  property p_ov_bit;
    @(posedge i_clk) disable iff (i_rst)
      i_sense.over_voltage |=> o_status[`LDR_ST_OV] && !o_status[0];
  endproperty
  a_ov_bit: assert property (p_ov_bit) else $error("ov bit");

  property p_tsd_bit;
    @(posedge i_clk) disable iff (i_rst)
      i_sense.over_temp |=> ##1 o_status[`LDR_ST_TSD];
  endproperty
  a_tsd_bit: assert property (p_tsd_bit) else $error("tsd bit");

  property p_ol_show;
    @(posedge i_clk) disable iff (i_rst)
      (|st.ol_flag) |=> o_status[8:1] == $past(st.ol_flag);
  endproperty
  a_ol_show: assert property (p_ol_show) else $error("ol bits");

  property p_ol_sum;
    @(posedge i_clk) disable iff (i_rst)
      !st.ctl[`LDR_CTL_DOL_BIT] && (|st.ol_flag) |=> !o_status[0];
  endproperty
  a_ol_sum: assert property (p_ol_sum) else $error("ol sum");

  property p_oc_sum;
    @(posedge i_clk) disable iff (i_rst)
      (|oc_flag) |=> !o_status[0];
  endproperty
  a_oc_sum: assert property (p_oc_sum) else $error("oc sum");

  property p_oc_set;
    @(posedge i_clk) disable iff (i_rst)
      i_sense.over_current[0] |=> oc_flag[0];
  endproperty
  a_oc_set: assert property (p_oc_set) else $error("oc flag");

  // a flag may only drop on a tick, a reset-bit clear or a reset
  property p_oc_fall;
    @(posedge i_clk) disable iff (i_rst)
      $fell(oc_flag[0]) |-> $past(tick) || $past(clear_oc) || $past(i_rst);
  endproperty
  a_oc_fall: assert property (p_oc_fall) else $error("oc fall");

  property p_start;
    @(posedge i_clk) disable iff (i_rst)
      st.act_sync[1] && st.mode == LDR_STANDBY |=> st.mode == LDR_STARTING;
  endproperty
  a_start: assert property (p_start) else $error("no start");

  property p_nrdy_set;
    @(posedge i_clk) disable iff (i_rst)
      st.mode != LDR_ACTIVE |=> o_not_ready;
  endproperty
  a_nrdy_set: assert property (p_nrdy_set) else $error("nrdy low");
endmodule

// File: hw/ldr_olfilt.sv
// open-load filter counters, one per driver stage
`timescale 1ns/10ps
`include "ldr_defines.svh"
module ldr_olfilt
  import ldr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_active,
  input wire logic [7:0] i_low_current,
  output logic [7:0] o_hit
);
  typedef struct packed {
    logic [7:0][15:0] cnt;
    logic [7:0] hit;
    logic [7:0] s1;
    logic [7:0] s2;
  } ldr_ol_state_type;
  ldr_ol_state_type st;
  ldr_ol_state_type next_st;
  always_comb begin
    next_st = st;
    next_st.s1 = i_low_current;
    next_st.s2 = st.s1;
    for (int i = 0; i < 8; i++) begin
      next_st.hit[i] = 1'b0;
      // counter restarts whenever current recovers or stage is off
      if (!(i_active[i] && st.s2[i])) begin
        next_st.cnt[i] = 16'h0000;
      end else if (st.cnt[i] == 16'(`LDR_OL_FILT_CYC - 1)) begin
        next_st.hit[i] = 1'b1;
      end else begin
        next_st.cnt[i] = st.cnt[i] + 16'h0001;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_hit = st.hit;
endmodule

// File: testbench/ldr_mcu.sv
// microcontroller model that writes control frames to the load driver
`timescale 1ns/10ps
module ldr_mcu
  import ldr_pkg::*;
(
  input wire logic i_clk,
  output logic o_frame_valid,
  output logic [15:0] o_frame,
  output logic o_reset_bit
);
  initial begin
    o_frame_valid = 1'b0;
    o_frame = 16'h0000;
    o_reset_bit = 1'b0;
  end
  // whole 16-bit frame in one strobe; bit 0 picks the register pair
  task automatic send(input logic [15:0] f);
    @(posedge i_clk);
    #2;
    o_frame = f;
    o_frame_valid = 1'b1;
    @(posedge i_clk);
    #2;
    o_frame_valid = 1'b0;
    // released data shows the inverse so stale values never look valid
    o_frame = ~f;
  endtask
  // reset bit write, needed before outputs come back after shutdown
  task automatic clear();
    @(posedge i_clk);
    #2;
    o_reset_bit = 1'b1;
    @(posedge i_clk);
    #2;
    o_reset_bit = 1'b0;
  endtask
endmodule

// File: testbench/tb.sv
// self-checking bench for the recovery, pwm and status register logic
`timescale 1ns/10ps
module tb
  import ldr_pkg::*;
();
  typedef struct {
    logic [15:0] m;
    logic [15:0] s;
    logic [4:0] d;
    logic [4:0] f;
  } ldr_note_type;
  ldr_note_type q[$];
  ldr_note_type nt;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic act = 1'b0;
  logic pwm = 1'b0;
  logic [4:0] oen = 5'h00;
  logic [4:0] foc = 5'h00;
  ldr_sense_type sense = '0;
  wire fv;
  wire rb;
  wire [15:0] frame;
  logic [15:0] o_status;
  logic [4:0] o_drive;
  logic [4:0] o_oc_flags;
  logic o_not_ready;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  ldr_mcu ldr_mcu_i (.i_clk(i_clk), .o_frame_valid(fv), .o_frame(frame),
    .o_reset_bit(rb));
  ldr_regs ldr_regs_i (.i_clk(i_clk), .i_rst(i_rst), .i_frame_valid(fv),
    .i_frame(frame), .i_active_req(act), .i_out_enable(oen),
    .i_reset_bit(rb), .i_first_oc(foc), .i_pwm_pin(pwm),
    .i_sense(sense), .o_status(o_status), .o_drive(o_drive),
    .o_oc_flags(o_oc_flags), .o_not_ready(o_not_ready));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge i_clk);
    #2;
  endtask
  task automatic expect_out(input logic [15:0] m, s, input logic [4:0] d, f);
    q.push_back('{m, s, d, f});
  endtask
  // monitor looks mid-cycle, where the registered outputs have settled
  always @(negedge i_clk) begin
    if (q.size() != 0) begin
      nt = q.pop_front();
      checks_done++;
      if ((o_status & nt.m) !== nt.s || o_drive !== nt.d ||
          o_oc_flags !== nt.f) begin
        n_fail++;
        $display("unexpected at %0t: status %h drive %h oc %h", $time,
          o_status, o_drive, o_oc_flags);
      end
    end
  end
  // ceiling covers startup, retry waits and the open-load filter
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h04DE4649));
    wait_cyc(16);
    i_rst = 1'b0;
    wait_cyc(3);
    expect_out(16'hFFFF, 16'h8400, 5'h00, 5'h00);
    checks_done++;
    if (o_not_ready !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: not ready low after reset", $time);
    end
    $display("test reset done");
    act = 1'b1;
    n = 0;
    while (o_not_ready !== 1'b0 && n < 37000) begin
      wait_cyc(1);
      n++;
    end
    wait_cyc(1);
    expect_out(16'hFFFF, 16'h8001, 5'h00, 5'h00);
    $display("test startup done");
    oen = 5'h01;
    ldr_mcu_i.send(16'h0003);
    for (int k = 0; k < 6; k++) begin
      pwm = 1'($urandom);
      wait_cyc(5);
      expect_out(16'h0001, 16'h0001, {4'h0, pwm}, 5'h00);
    end
    pwm = 1'b0;
    ldr_mcu_i.send(16'h0000);
    wait_cyc(5);
    expect_out(16'h0001, 16'h0001, 5'h00, 5'h00);
    ldr_mcu_i.send(16'h0001);
    wait_cyc(5);
    expect_out(16'h0001, 16'h0001, 5'h01, 5'h00);
    $display("test pwm done");
    sense.over_current[0] = 1'b1;
    foc = 5'h02;
    wait_cyc(4);
    expect_out(16'h0001, 16'h0000, 5'h00, 5'h03);
    sense.over_current[0] = 1'b0;
    foc = 5'h00;
    ldr_mcu_i.clear();
    wait_cyc(4);
    expect_out(16'h0001, 16'h0001, 5'h01, 5'h00);
    for (int k = 0; k < 2; k++) begin
      ldr_mcu_i.send(k == 0 ? 16'h0041 : 16'h2041);
      sense.over_current[0] = 1'b1;
      wait_cyc(1);
      sense.over_current[0] = 1'b0;
      wait_cyc(8100);
      // long duty holds the output off for four ticks, short for one
      expect_out(16'h0000, 16'h0000, {4'h0, k[0] == 1'b0},
        {4'h0, k[0]});
    end
    // second high side switched on with low current while retry runs out
    oen = 5'h11;
    sense.open_load_raw[7] = 1'b1;
    wait_cyc(40100);
    expect_out(16'h0101, 16'h0100, 5'h11, 5'h00);
    $display("test recovery done");
    sense.open_load_raw[7] = 1'b0;
    oen = 5'h01;
    ldr_mcu_i.send(16'h4001);
    wait_cyc(3);
    expect_out(16'h0101, 16'h0101, 5'h01, 5'h00);
    ldr_mcu_i.send(16'h0001);
    ldr_mcu_i.clear();
    wait_cyc(4);
    expect_out(16'h0101, 16'h0001, 5'h01, 5'h00);
    $display("test open load done");
    for (int k = 0; k < 2; k++) begin
      {sense.over_voltage, sense.under_voltage} = 2'b10 >> k;
      wait_cyc(3);
      expect_out(16'h6001, 16'h4000 >> k, 5'h00, 5'h00);
      {sense.over_voltage, sense.under_voltage} = 2'b00;
      wait_cyc(4);
    end
    sense.temp_warning = 1'b1;
    wait_cyc(3);
    expect_out(16'h0801, 16'h0800, 5'h01, 5'h00);
    sense.temp_warning = 1'b0;
    sense.over_temp = 1'b1;
    wait_cyc(3);
    sense.over_temp = 1'b0;
    wait_cyc(3);
    expect_out(16'h1001, 16'h1000, 5'h00, 5'h00);
    ldr_mcu_i.clear();
    wait_cyc(4);
    expect_out(16'h1001, 16'h0001, 5'h01, 5'h00);
    wait_cyc(2);
    $display("test faults done");
    end_of_test();
  end
endmodule
